// >>> common/sampler_eval_pkg.sv
// Constants and types for the evaluate-message dispatch path.
// Assumes a single sampler clock domain; no bus, all controls are ports.
package sampler_eval_pkg;

	// Tiling kinds of the referenced surface
	localparam logic [1:0] TILE_LINEAR   = 2'h0;
	localparam logic [1:0] TILE_LEGACY   = 2'h1;
	localparam logic [1:0] TILE_STD64K   = 2'h2;

	// Surface types
	localparam logic [1:0] SURF_2D_CUBE  = 2'h0;
	localparam logic [1:0] SURF_3D       = 2'h1;
	localparam logic [1:0] SURF_BUFFER   = 2'h2;
	localparam logic [1:0] SURF_OTHER    = 2'h3;

	// Bits per element classes
	localparam logic [2:0] BPE_8         = 3'h0;
	localparam logic [2:0] BPE_16        = 3'h1;
	localparam logic [2:0] BPE_32        = 3'h2;
	localparam logic [2:0] BPE_64        = 3'h3;
	localparam logic [2:0] BPE_128       = 3'h4;

	// Nibble select address bits
	localparam int NIB_BIT_LOW  = 6;
	localparam int NIB_BIT_HIGH = 7;

	// Pairing bit positions
	localparam logic [3:0] PAIR_B6  = 4'h6;
	localparam logic [3:0] PAIR_B7  = 4'h7;
	localparam logic [3:0] PAIR_B8  = 4'h8;
	localparam logic [3:0] PAIR_B9  = 4'h9;
	localparam logic [3:0] PAIR_B12 = 4'hC;

	// Widths
	localparam int ADDR_W  = 32;
	localparam int TEXEL_W = 64;

	// Message dispatch outcome
	typedef enum logic [3:0] {
		DISP_IDLE    = 4'h1,
		DISP_SAMPLE  = 4'h2,
		DISP_FORWARD = 4'h4,
		DISP_FLUSH   = 4'h8
	} dispatch_e;

endpackage

// >>> common/feedback_addr_if.sv
// Interface carrying surface layout and address to the feedback mapper.
// Assumes both ends share the sampler clock.
`timescale 1ns/1ps
interface feedback_addr_if;
	logic [1:0]  tiling;    // Tiling kind
	logic [1:0]  surfType;  // Surface type
	logic [2:0]  bpe;       // Element size class
	logic [31:0] addr;      // Main surface address
	logic [5:0]  byteSel;   // Byte within the 64-byte page value
	logic        nibSel;    // Nibble within that byte
	logic [3:0]  pairBit;   // Compression pairing bit position
	modport requester (output tiling, surfType, bpe, addr,
		input byteSel, nibSel, pairBit);
	modport mapper (input tiling, surfType, bpe, addr,
		output byteSel, nibSel, pairBit);
endinterface

// >>> hdl/feedback_addr_map.sv
// Combinational feedback byte/nibble selector and pairing bit chooser.
// Assumes inputs are stable in the cycle they are sampled by the caller.
`timescale 1ns/1ps
module feedback_addr_map (
	// Layout and address
	feedback_addr_if.mapper m
);
	// Byte and nibble selection per page
	always_comb begin
		m.byteSel = {m.addr[13], m.addr[12], m.addr[11], m.addr[10],
			m.addr[8], m.addr[7]};
		m.nibSel  = m.addr[sampler_eval_pkg::NIB_BIT_LOW];
		if (m.tiling == sampler_eval_pkg::TILE_LINEAR) begin
			m.byteSel = m.addr[13:8];
			m.nibSel  = m.addr[sampler_eval_pkg::NIB_BIT_HIGH];
		end else if (m.tiling == sampler_eval_pkg::TILE_STD64K) begin
			if (m.surfType == sampler_eval_pkg::SURF_3D) begin
				if (m.bpe == sampler_eval_pkg::BPE_16) begin
					m.byteSel = {m.addr[13], m.addr[11:7]};
				end
			end else if (m.bpe != sampler_eval_pkg::BPE_8) begin
				m.byteSel = m.addr[13:8];
			end
			if (m.bpe == sampler_eval_pkg::BPE_64 ||
				m.bpe == sampler_eval_pkg::BPE_128) begin
				m.nibSel = m.addr[sampler_eval_pkg::NIB_BIT_HIGH];
			end
		end
	end

	// Compression pairing bit selection
	always_comb begin
		m.pairBit = sampler_eval_pkg::PAIR_B6;
		if (m.surfType == sampler_eval_pkg::SURF_2D_CUBE) begin
			if (m.tiling == sampler_eval_pkg::TILE_LEGACY) begin
				m.pairBit = sampler_eval_pkg::PAIR_B9;
			end else if (m.tiling == sampler_eval_pkg::TILE_STD64K) begin
				case (m.bpe)
					sampler_eval_pkg::BPE_8:  m.pairBit = sampler_eval_pkg::PAIR_B9;
					sampler_eval_pkg::BPE_16: m.pairBit = sampler_eval_pkg::PAIR_B7;
					sampler_eval_pkg::BPE_32: m.pairBit = sampler_eval_pkg::PAIR_B7;
					default:                  m.pairBit = sampler_eval_pkg::PAIR_B6;
				endcase
			end
		end else if (m.surfType == sampler_eval_pkg::SURF_3D) begin
			if (m.tiling == sampler_eval_pkg::TILE_LEGACY) begin
				m.pairBit = sampler_eval_pkg::PAIR_B9;
			end else if (m.tiling == sampler_eval_pkg::TILE_STD64K) begin
				case (m.bpe)
					sampler_eval_pkg::BPE_8:  m.pairBit = sampler_eval_pkg::PAIR_B9;
					sampler_eval_pkg::BPE_16: m.pairBit = sampler_eval_pkg::PAIR_B12;
					sampler_eval_pkg::BPE_32: m.pairBit = sampler_eval_pkg::PAIR_B9;
					default:                  m.pairBit = sampler_eval_pkg::PAIR_B8;
				endcase
			end
		end
	end
endmodule

// >>> hdl/sampler_evaluate_dispatch.sv
// Evaluate-message dispatch: classifies messages, forwards texels,
// handles flush drain and reports feedback/pairing address selections.
// Assumes one valid message per handshake, synchronous inputs.
//
// Summary of operation
// - Evaluate decoded like sample, zero return length.
// - Zero length, procedural: forward texels to spawner.
// - Zero length, not procedural: drop message.
// - Nonzero length: normal sample, return results.
// - Page byte chosen from six address bits.
// - Nibble chosen by address bit 6 or 7.
// - Second flush return waits for spawner drain.
// - Compression pairs 64-byte halves into 128-byte line.
// - Pairing bit chosen by surface and tiling.
`timescale 1ns/1ps
module sampler_evaluate_dispatch #(
	parameter int TEXEL_W = sampler_eval_pkg::TEXEL_W,
	parameter int RLEN_W  = 5
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// Incoming shader message
	input  wire logic               msgValid,
	output logic                    msgReady,
	input  wire logic [RLEN_W-1:0]  msgRetLen,
	input  wire logic               msgIsFlush,
	input  wire logic               surfProcedural,
	input  wire logic [1:0]         surfTiling,
	input  wire logic [1:0]         surfType,
	input  wire logic [2:0]         surfBpe,
	input  wire logic [31:0]        surfAddr,
	input  wire logic [TEXEL_W-1:0] msgTexel,
	// Normal sample path
	output logic                    sampleValid,
	output logic [TEXEL_W-1:0]      sampleTexel,
	input  wire logic               sampleDone,
	// Texel shader spawner
	output logic                    spawnValid,
	output logic [TEXEL_W-1:0]      spawnTexel,
	input  wire logic               spawnReady,
	output logic                    spawnEndOfThread,
	input  wire logic               spawnerIdle,
	// Return to shader
	output logic                    returnValid,
	// Status
	output logic                    dropPulse,
	output logic [5:0]              feedbackByte,
	output logic                    feedbackNibble,
	output logic [3:0]              pairBitPos
);
	// Elaboration check: a zero-width texel or length field has no meaning
	// and would leave the zero-length decode with no bits to test
	if (TEXEL_W < 1 || RLEN_W < 1) begin : g_badWidth
		$error("sampler_evaluate_dispatch: bad widths");
	end

	// State and take decode
	sampler_eval_pkg::dispatch_e stateQ; // Dispatch state
	logic accept;                         // Message taken this cycle
	logic zeroLen;                        // Return length is zero

	feedback_addr_if fa();                // Address mapper link

	// The mapper is purely combinational; its results are registered below
	// Address mapper: inputs from current message
	assign fa.tiling   = surfTiling;
	assign fa.surfType = surfType;
	assign fa.bpe      = surfBpe;
	assign fa.addr     = surfAddr;

	feedback_addr_map mapper (
		.m (fa.mapper)
	);

	// A take needs both sides high at one edge; ready already excludes busy
	// Accept only when idle; classification uses length, flush and procedural flags only
	assign accept  = msgValid && msgReady;
	assign zeroLen = (msgRetLen == '0);

	// Ready is registered: high only in idle
	// It drops on the edge that takes a message, so a held valid can never
	// be taken twice; the earliest next take is two edges later
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			msgReady <= 1'b0;
		end else begin
			msgReady <= (stateQ == sampler_eval_pkg::DISP_IDLE) && !accept;
		end
	end

	// Dispatch state machine
	// Idle:    waits for a message; drops and end-of-thread flushes stay here
	// Sample:  waits for the sampling core to finish
	// Forward: waits for the spawner to take the texel
	// Flush:   withholds the return until the spawner has drained
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stateQ <= sampler_eval_pkg::DISP_IDLE;
		end else begin
			case (stateQ)
				sampler_eval_pkg::DISP_IDLE: begin
					if (accept) begin
						if (msgIsFlush && !zeroLen) begin
							stateQ <= sampler_eval_pkg::DISP_FLUSH;
						end else if (msgIsFlush) begin
							stateQ <= sampler_eval_pkg::DISP_IDLE;
						end else if (!zeroLen) begin
							stateQ <= sampler_eval_pkg::DISP_SAMPLE;
						end else if (surfProcedural) begin
							stateQ <= sampler_eval_pkg::DISP_FORWARD;
						end else begin
							stateQ <= sampler_eval_pkg::DISP_IDLE;
						end
					end
				end
				sampler_eval_pkg::DISP_SAMPLE: begin
					if (sampleDone) begin
						stateQ <= sampler_eval_pkg::DISP_IDLE;
					end
				end
				sampler_eval_pkg::DISP_FORWARD: begin
					if (spawnValid && spawnReady) begin
						stateQ <= sampler_eval_pkg::DISP_IDLE;
					end
				end
				sampler_eval_pkg::DISP_FLUSH: begin
					if (spawnerIdle && !spawnValid) begin
						stateQ <= sampler_eval_pkg::DISP_IDLE;
					end
				end
				default: stateQ <= sampler_eval_pkg::DISP_IDLE;
			endcase
		end
	end

	// Normal sample request to the sampling core
	// Level request, cleared by the core's done pulse
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sampleValid <= 1'b0;
			sampleTexel <= '0;
		end else if (accept && !zeroLen && !msgIsFlush) begin
			sampleValid <= 1'b1;
			sampleTexel <= msgTexel;
		end else if (sampleDone) begin
			sampleValid <= 1'b0;
		end
	end

	// Texel forwarding to spawner; data frozen while stalled
	// The texel register loads only on a take, which happens only in idle,
	// so it cannot move while valid waits for ready
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			spawnValid <= 1'b0;
			spawnTexel <= '0;
		end else if (accept && zeroLen && surfProcedural && !msgIsFlush) begin
			spawnValid <= 1'b1;
			spawnTexel <= msgTexel;
		end else if (spawnReady) begin
			spawnValid <= 1'b0;
		end
	end

	// First flush (zero length) signals end of thread to spawner
	// One-cycle pulse; this flush itself gets no return
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			spawnEndOfThread <= 1'b0;
		end else begin
			spawnEndOfThread <= accept && msgIsFlush && zeroLen;
		end
	end

	// Return pulse: sample finished, or flush drained
	// A flush waits for the spawner to report idle and for any texel still
	// on offer, since that texel is spawner work not yet counted as busy
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			returnValid <= 1'b0;
		end else begin
			returnValid <=
				(stateQ == sampler_eval_pkg::DISP_SAMPLE && sampleDone) ||
				(stateQ == sampler_eval_pkg::DISP_FLUSH && spawnerIdle &&
				!spawnValid);
		end
	end

	// Unsupported zero-length, non-procedural message is dropped
	// Nothing is sampled or forwarded; the pulse only reports the drop
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dropPulse <= 1'b0;
		end else begin
			dropPulse <= accept && zeroLen && !surfProcedural &&
				!msgIsFlush;
		end
	end

	// Registered feedback and pairing selections for the accepted message
	// Held until the next take so the values stay readable after the pulse
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			feedbackByte   <= '0;
			feedbackNibble <= 1'b0;
			pairBitPos     <= sampler_eval_pkg::PAIR_B6;
		end else if (accept) begin
			feedbackByte   <= fa.byteSel;
			feedbackNibble <= fa.nibSel;
			pairBitPos     <= fa.pairBit;
		end
	end
endmodule

// >>> test/spawner_model.sv
// Behavioural texel shader spawner at the far side of the dispatch block.
// Assumes the sampler clock; it answers just after each rising edge.
`timescale 1ns/1ps
module spawner_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Texel handshake and stall mode
	input  wire logic spawnValid,
	input  wire logic slow,
	// Answers to the dispatch block
	output logic      spawnReady,
	output logic      spawnerIdle
);
	logic       hs;          // Handshake seen at this edge
	logic [3:0] pend = 4'h0; // Shader work still in flight
	logic [1:0] cyc = 2'h0;  // Stall pattern counter
	initial spawnReady = 1'b0;
	initial spawnerIdle = 1'b1;
	// Take texels, stall on a pattern when slow, report drain
	always @(posedge clk) begin
		hs = spawnValid && spawnReady;
		#1;
		cyc = cyc + 2'h1;
		if (sys_rst) begin
			pend = 4'h0;
		end else if (hs) begin
			pend = 4'h6;
		end else if (pend != 4'h0) begin
			pend = pend - 4'h1;
		end
		spawnReady = !sys_rst && (!slow || cyc == 2'h0);
		spawnerIdle = pend == 4'h0;
	end
endmodule

// >>> test/sampler_evaluate_dispatch_monitor.sv
// Assertions on the dispatch block's top ports.
// Assumes one clock domain with asynchronous reset sys_rst.
`timescale 1ns/1ps
module dispatch_monitor #(
	parameter int TEXEL_W = 64,
	parameter int RLEN_W  = 5
) (
	input wire logic               clk,
	input wire logic               sys_rst,
	input wire logic               msgValid,
	input wire logic               msgReady,
	input wire logic [RLEN_W-1:0]  msgRetLen,
	input wire logic               msgIsFlush,
	input wire logic               surfProcedural,
	input wire logic [1:0]         surfTiling,
	input wire logic [1:0]         surfType,
	input wire logic [31:0]        surfAddr,
	input wire logic               sampleValid,
	input wire logic               sampleDone,
	input wire logic               spawnValid,
	input wire logic [TEXEL_W-1:0] spawnTexel,
	input wire logic               spawnReady,
	input wire logic               spawnEndOfThread,
	input wire logic               spawnerIdle,
	input wire logic               returnValid,
	input wire logic               dropPulse,
	input wire logic [5:0]         feedbackByte,
	input wire logic               feedbackNibble,
	input wire logic [3:0]         pairBitPos
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire tk = msgValid && msgReady; // Message taken
	wire zl = msgRetLen == '0;      // Zero return length
	wire lg = surfTiling == 2'h1;   // Legacy tiling
	wire nibLo = surfAddr[6];       // Legacy nibble bit
	wire [5:0] byteLg = {surfAddr[13:10], surfAddr[8:7]}; // Legacy byte
	a_drop_plain: assert property (
		tk && zl && !msgIsFlush && !surfProcedural |=>
		dropPulse && !spawnValid && !sampleValid) else $error("no drop");
	a_fwd_eval: assert property (
		tk && zl && !msgIsFlush && surfProcedural |=>
		spawnValid && !sampleValid) else $error("no forward");
	a_sample_nonzero: assert property (
		tk && !zl && !msgIsFlush |=> sampleValid && !spawnValid)
		else $error("no sample");
	a_spawn_hold: assert property (
		spawnValid && !spawnReady |=> spawnValid && $stable(spawnTexel))
		else $error("spawn texel moved");
	a_eot_pulse: assert property (
		tk && zl && msgIsFlush |=> spawnEndOfThread ##1 !spawnEndOfThread)
		else $error("no end of thread");
	a_return_cause: assert property (
		returnValid |-> $past(spawnerIdle) || $past(sampleDone) ||
		$past(sampleDone, 2)) else $error("early return");
	a_nibble_legacy: assert property (
		tk && lg |=> feedbackNibble == $past(nibLo))
		else $error("nibble");
	a_byte_legacy: assert property (
		tk && lg |=> feedbackByte == $past(byteLg))
		else $error("byte select");
	a_pair_legacy: assert property (
		tk && lg && !surfType[1] |=> pairBitPos == 4'h9)
		else $error("pair bit");
	a_busy_after: assert property (
		tk |=> !msgReady) else $error("ready after take");
	c_drop: cover property (dropPulse);
	c_eot: cover property (spawnEndOfThread);
	c_stall: cover property (spawnValid && !spawnReady);
	c_forward: cover property (tk && zl && surfProcedural && !msgIsFlush);
	c_flush_wait: cover property (tk && !zl && msgIsFlush && !spawnerIdle);
endmodule
bind sampler_evaluate_dispatch dispatch_monitor #(.TEXEL_W(TEXEL_W),
	.RLEN_W(RLEN_W)) uMon (.clk(clk), .sys_rst(sys_rst),
	.msgValid(msgValid), .msgReady(msgReady), .msgRetLen(msgRetLen),
	.msgIsFlush(msgIsFlush), .surfProcedural(surfProcedural),
	.surfTiling(surfTiling), .surfType(surfType), .surfAddr(surfAddr),
	.sampleValid(sampleValid), .sampleDone(sampleDone),
	.spawnValid(spawnValid), .spawnTexel(spawnTexel),
	.spawnReady(spawnReady), .spawnEndOfThread(spawnEndOfThread),
	.spawnerIdle(spawnerIdle), .returnValid(returnValid),
	.dropPulse(dropPulse), .feedbackByte(feedbackByte),
	.feedbackNibble(feedbackNibble), .pairBitPos(pairBitPos));

// >>> test/tb_sampler_evaluate_dispatch.sv
// Self-checking bench for the evaluate dispatch block.
// Assumes the spawner model; the bench plays the sample core.
`timescale 1ns/1ps
module tb_sampler_evaluate_dispatch;
	logic        clk = 1'b0, sys_rst = 1'b1, msgValid = 1'b0, slow = 1'b0;
	logic        msgIsFlush = 1'b0, surfProcedural = 1'b0, sampleDone = 1'b0;
	logic [4:0]  msgRetLen = 5'h00;
	logic [1:0]  surfTiling = 2'h1, surfType = 2'h0;
	logic [2:0]  surfBpe = 3'h0;
	logic [31:0] surfAddr = 32'h0;
	logic [63:0] msgTexel = 64'h0, sampleTexel, spawnTexel;
	logic        msgReady, sampleValid, spawnValid, spawnReady, spawnerIdle;
	logic        spawnEndOfThread, returnValid, dropPulse, feedbackNibble;
	logic [5:0]  feedbackByte;
	logic [3:0]  pairBitPos;
	int          seed = 32'h110d, n_mismatch = 0, cmp_count = 0;
	always #20 clk = ~clk; // 25 MHz
	sampler_evaluate_dispatch DUT (.clk(clk), .sys_rst(sys_rst),
		.msgValid(msgValid), .msgReady(msgReady), .msgRetLen(msgRetLen),
		.msgIsFlush(msgIsFlush), .surfProcedural(surfProcedural),
		.surfTiling(surfTiling), .surfType(surfType), .surfBpe(surfBpe),
		.surfAddr(surfAddr), .msgTexel(msgTexel), .sampleValid(sampleValid),
		.sampleTexel(sampleTexel), .sampleDone(sampleDone),
		.spawnValid(spawnValid), .spawnTexel(spawnTexel),
		.spawnReady(spawnReady), .spawnEndOfThread(spawnEndOfThread),
		.spawnerIdle(spawnerIdle), .returnValid(returnValid),
		.dropPulse(dropPulse), .feedbackByte(feedbackByte),
		.feedbackNibble(feedbackNibble), .pairBitPos(pairBitPos));
	spawner_model uSpawn (.clk(clk), .sys_rst(sys_rst), .spawnValid(spawnValid),
		.slow(slow), .spawnReady(spawnReady), .spawnerIdle(spawnerIdle));
	// Count a comparison, report a miss
	task automatic check(input logic ok, input string what);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	// Pairing bit expected for legacy or standard tiling
	function automatic logic [3:0] pairExp(input logic [1:0] t, s,
		input logic [2:0] b);
		if (s[1] || t == 2'h0) return 4'h6;
		if (t == 2'h1) return 4'h9;
		case (b)
			3'h0: return 4'h9;
			3'h1: return s[0] ? 4'hC : 4'h7;
			3'h2: return s[0] ? 4'h9 : 4'h7;
			default: return s[0] ? 4'h8 : 4'h6;
		endcase
	endfunction
	// Page byte expected for each tiling, type and element size
	function automatic logic [5:0] byteExp(input logic [1:0] t, s,
		input logic [2:0] b, input logic [31:0] a);
		if (t == 2'h2 && s == 2'h1 && b == 3'h1) return {a[13], a[11:7]};
		if (t == 2'h0 || (t == 2'h2 && s != 2'h1 && b != 3'h0))
			return a[13:8];
		return {a[13:10], a[8:7]};
	endfunction
	// Offer one message, then check its outcome and any return
	task automatic send(input logic [4:0] len, input logic fl, pr);
		int  n;
		logic zl, big;
		zl = len == 5'h00;
		msgRetLen = len;
		msgIsFlush = fl;
		surfProcedural = pr;
		surfTiling = 2'($unsigned($random(seed)) % 3);
		if (zl && pr && !fl) surfTiling = 2'h2;
		surfType = 2'($random(seed));
		surfBpe = 3'($unsigned($random(seed)) % 5);
		surfAddr = $random(seed);
		msgTexel = {$random(seed), $random(seed)};
		big = surfTiling == 2'h0 || (surfTiling == 2'h2 && surfBpe >= 3'h3);
		msgValid = 1'b1;
		n = 0;
		@(posedge clk);
		while (msgReady !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		#1 msgValid = 1'b0;
		check(dropPulse === (zl && !fl && !pr), "drop");
		check(spawnValid === (zl && !fl && pr), "forward");
		check(sampleValid === (!zl && !fl), "sample");
		check(spawnEndOfThread === (zl && fl), "end of thread");
		check(pairBitPos === pairExp(surfTiling, surfType, surfBpe), "pair");
		if (surfType == 2'h0 || surfTiling == 2'h0)
			check(feedbackNibble === surfAddr[big ? 7 : 6], "nibble");
		check(feedbackByte ===
			byteExp(surfTiling, surfType, surfBpe, surfAddr), "byte");
		if (sampleValid === 1'b1) begin
			check(sampleTexel === msgTexel, "sample texel");
			@(posedge clk);
			#1 sampleDone = 1'b1;
			@(posedge clk);
			#1 sampleDone = 1'b0;
		end
		for (n = 0; spawnValid === 1'b1 && n < 50; n++) begin
			check(spawnTexel === msgTexel, "spawn texel");
			@(posedge clk);
			#1;
		end
		for (n = 0; returnValid !== 1'b1 && n < (zl ? 2 : 20); n++) begin
			@(posedge clk);
			#1;
		end
		check(returnValid === !zl, "return");
		if (fl && !zl) check(spawnerIdle === 1'b1, "drained");
	endtask
	// Print counts and verdict, then stop
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Corner table first, then random traffic with stalls
	initial begin
		// Kernel order: evaluate, then flush pair
		logic [4:0] lenT [6] = '{5'h00, 5'h05, 5'h01, 5'h00, 5'h00, 5'h03};
		logic       flT [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
		logic       prT [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		@(posedge clk);
		#1;
		for (int i = 0; i < 48; i++) begin
			slow = i[1];
			if (i < 6) send(lenT[i], flT[i], prT[i]);
			else send($random(seed) & 1 ? 5'($random(seed)) : 5'h00,
				($random(seed) & 7) == 0, $random(seed) & 1);
			$display("test %0d done", i);
		end
		complete_run();
	end
	// Watchdog well past the expected run length
	initial begin
		#(40 * 10000);
		n_mismatch++;
		complete_run();
	end
endmodule
